// File: core/mps_port_switch.sv
// mii port switch: routes the mac to the internal phy or the external mii port
// assumes select inputs come from core-clock logic; mii pins are asynchronous
// Notes on behaviour
// - two-bit source select switches and gates rx and tx clocks without glitches.
// - port select muxes all mii signals except management and clocks.
// - management port follows its own select, independent of data routing.
// - source code 10 removes both mii clocks from internal logic.
// - port select moves rxd, rx valid/error, txd, tx enable, crs, col.
`timescale 1ns/100ps
module mps_port_switch
  import mps_pkg::*;
(
  // core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration
  input wire logic externalPortSelect,
  input wire logic managementPortSelect,
  input wire logic [1:0] clockSourceSelect,
  // status
  output logic clocksRunning,
  output logic clockSourceExternal,
  output logic routingMismatch,
  output logic unsafeSwitch,
  // raw mii clocks
  input wire logic intRxClk,
  input wire logic intTxClk,
  input wire logic extRxClk,
  input wire logic extTxClk,
  // mac side
  output logic macRxClk,
  output logic macTxClk,
  input wire logic [MPS_NIB_W-1:0] macTxd,
  input wire logic macTxEn,
  output logic [MPS_NIB_W-1:0] macRxd,
  output logic macRxDv,
  output logic macRxEr,
  output logic macCrs,
  output logic macCol,
  // internal phy side
  output logic [MPS_NIB_W-1:0] intTxd,
  output logic intTxEn,
  input wire logic [MPS_NIB_W-1:0] intRxd,
  input wire logic intRxDv,
  input wire logic intRxEr,
  input wire logic intCrs,
  input wire logic intCol,
  // external port side
  output logic [MPS_NIB_W-1:0] extTxd,
  output logic extTxEn,
  input wire logic [MPS_NIB_W-1:0] extRxd,
  input wire logic extRxDv,
  input wire logic extRxEr,
  input wire logic extCrs,
  input wire logic extCol,
  // management master on the mac side
  input wire logic macMdc,
  input wire logic macMdioOut,
  input wire logic macMdioOe,
  output logic macMdioIn,
  // management to internal phy
  output logic intMdc,
  output logic intMdioOut,
  output logic intMdioOe,
  input wire logic intMdioIn,
  // management to external port
  output logic extMdc,
  output logic extMdioOut,
  output logic extMdioOe,
  input wire logic extMdioIn
);
  import mps_pkg::*;

  mps_clk_if clkIf ();
  mps_top_state_type st_r;
  mps_top_state_type st_nxt;

  assign clkIf.clkSel = clockSourceSelect;
  assign clkIf.phyClks = {extTxClk, extRxClk, intTxClk, intRxClk};

  mps_clock_select u_clock_select (
    .clock(clock),
    .rst_n(rst_n),
    .clkIf(clkIf.sel)
  );

  // clocks come out of the glitch-free selector
  assign macRxClk = clkIf.rxClk;
  assign macTxClk = clkIf.txClk;
  assign clocksRunning = clkIf.clocksRunning;
  assign clockSourceExternal = clkIf.extActive;

  // pure routing: registering would add latency to the mii timing path
  always_comb begin
    // data and control lines follow port select
    if (externalPortSelect) begin
      macRxd = extRxd;
      macRxDv = extRxDv;
      macRxEr = extRxEr;
      macCrs = extCrs;
      macCol = extCol;
      extTxd = macTxd;
      extTxEn = macTxEn;
      intTxd = '0;
      intTxEn = 1'b0;
    end else begin
      macRxd = intRxd;
      macRxDv = intRxDv;
      macRxEr = intRxEr;
      macCrs = intCrs;
      macCol = intCol;
      intTxd = macTxd;
      intTxEn = macTxEn;
      extTxd = '0;
      extTxEn = 1'b0;
    end
  end

  always_comb begin
    // management routed by its own select
    if (managementPortSelect) begin
      extMdc = macMdc;
      extMdioOut = macMdioOut;
      extMdioOe = macMdioOe;
      macMdioIn = extMdioIn;
      intMdc = 1'b0;
      intMdioOut = 1'b0;
      intMdioOe = 1'b0;
    end else begin
      intMdc = macMdc;
      intMdioOut = macMdioOut;
      intMdioOe = macMdioOe;
      macMdioIn = intMdioIn;
      extMdc = 1'b0;
      extMdioOut = 1'b0;
      extMdioOe = 1'b0;
    end
  end

  // status watch on the software sequence; the device cannot enforce it
  always_comb begin
    st_nxt = st_r;
    st_nxt.portSelPrev = externalPortSelect;
    // running clocks must come from the routed port
    st_nxt.routingMismatch = clkIf.clocksRunning && (clkIf.extActive != externalPortSelect);
    // flag a routing change while clocks still run
    st_nxt.unsafeSwitch = clkIf.clocksRunning && (externalPortSelect != st_r.portSelPrev);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= '{routingMismatch: 1'b0, unsafeSwitch: 1'b0, portSelPrev: MPS_SRC_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign routingMismatch = st_r.routingMismatch;
  assign unsafeSwitch = st_r.unsafeSwitch;

  AST_RX_ROUTE: assert property (@(posedge clock) disable iff (!rst_n)
    externalPortSelect |-> macRxd == extRxd && macRxDv == extRxDv && macCol == extCol && !intTxEn)
    else $error("receive path not routed to external port");

  AST_TX_ROUTE: assert property (@(posedge clock) disable iff (!rst_n)
    !externalPortSelect |-> intTxd == macTxd && intTxEn == macTxEn && extTxd == '0 && macCrs == intCrs)
    else $error("transmit path not routed to internal phy");

  AST_MGMT_ROUTE: assert property (@(posedge clock) disable iff (!rst_n)
    managementPortSelect != externalPortSelect && managementPortSelect
    |-> extMdc == macMdc && macMdioIn == extMdioIn && !intMdioOe && !intMdc)
    else $error("management not routed independently");

  AST_GATE_OUT: assert property (@(posedge clock) disable iff (!rst_n)
    clockSourceSelect == MPS_CLKSEL_GATED [*8] |-> !macRxClk && !macTxClk)
    else $error("mac clocks still active after gating");

  AST_MISMATCH: assert property (@(posedge clock) disable iff (!rst_n)
    clocksRunning && (clockSourceExternal != externalPortSelect) |=> routingMismatch)
    else $error("routing mismatch not reported");

  CVR_SWITCH_EXT: cover property (@(posedge clock) disable iff (!rst_n)
    !clocksRunning ##1 clocksRunning && clockSourceExternal && externalPortSelect);
  CVR_MGMT_SPLIT: cover property (@(posedge clock) disable iff (!rst_n)
    managementPortSelect && !externalPortSelect && clocksRunning);
endmodule

// File: core/mps_pkg.sv
// constants and types shared by the mii port switch
// assumes a single 10 MHz core clock and mii clocks sampled in that domain
package mps_pkg;

  // clock source selection codes
  localparam logic [1:0] MPS_CLKSEL_INT = 2'h0;
  localparam logic [1:0] MPS_CLKSEL_EXT = 2'h1;
  localparam logic [1:0] MPS_CLKSEL_GATED = 2'h2;
  localparam logic [1:0] MPS_CLKSEL_RSVD = 2'h3;

  // raw mii clock bundle layout
  localparam int MPS_NUM_CLK = 4;
  localparam int MPS_IDX_INT_RX = 0;
  localparam int MPS_IDX_INT_TX = 1;
  localparam int MPS_IDX_EXT_RX = 2;
  localparam int MPS_IDX_EXT_TX = 3;

  // mii data nibble width
  localparam int MPS_NIB_W = 4;

  // reset values
  localparam logic [3:0] MPS_SYNC_RESET = 4'h0;
  localparam logic MPS_SRC_RESET = 1'b0;

  // gray-coded along gated -> run -> stopping; stopping -> gated flips both bits
  typedef enum logic [1:0] {
    MPS_GATED = 2'b00,
    MPS_RUN = 2'b01,
    MPS_STOPPING = 2'b11
  } mps_clk_state_type;

  typedef struct packed {
    logic [MPS_NUM_CLK-1:0] sync1;
    logic [MPS_NUM_CLK-1:0] sync2;
    mps_clk_state_type state;
    logic extSrc;
    logic rxClk;
    logic txClk;
  } mps_csel_state_type;

  typedef struct packed {
    logic routingMismatch;
    logic unsafeSwitch;
    logic portSelPrev;
  } mps_top_state_type;

endpackage

// File: core/mps_clk_if.sv
// carrier between the port switch top and its clock selector
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface mps_clk_if;
  logic [1:0] clkSel;
  logic [3:0] phyClks;
  logic rxClk;
  logic txClk;
  logic clocksRunning;
  logic extActive;

  modport ctrl (
    output clkSel,
    output phyClks,
    input rxClk,
    input txClk,
    input clocksRunning,
    input extActive
  );

  modport sel (
    input clkSel,
    input phyClks,
    output rxClk,
    output txClk,
    output clocksRunning,
    output extActive
  );
endinterface

// File: core/mps_clock_select.sv
// glitch-free selector and gate for the mac receive and transmit clocks
// assumes raw mii clocks are far slower than the core clock
`timescale 1ns/100ps
module mps_clock_select
  import mps_pkg::*;
(
  // core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // selection and clocks
  mps_clk_if.sel clkIf
);
  import mps_pkg::*;

  mps_csel_state_type cur_r;
  mps_csel_state_type cur_nxt;
  logic reqValid;
  logic reqExt;
  logic srcRx;
  logic srcTx;
  logic newRx;
  logic newTx;

  always_comb begin
    cur_nxt = cur_r;
    // two-stage synchroniser per clock
    cur_nxt.sync1 = clkIf.phyClks;
    cur_nxt.sync2 = cur_r.sync1;
    // 00 internal, 01 external, others gate
    reqValid = (clkIf.clkSel == MPS_CLKSEL_INT) || (clkIf.clkSel == MPS_CLKSEL_EXT);
    reqExt = (clkIf.clkSel == MPS_CLKSEL_EXT);
    srcRx = cur_r.extSrc ? cur_r.sync2[MPS_IDX_EXT_RX] : cur_r.sync2[MPS_IDX_INT_RX];
    srcTx = cur_r.extSrc ? cur_r.sync2[MPS_IDX_EXT_TX] : cur_r.sync2[MPS_IDX_INT_TX];
    newRx = reqExt ? cur_r.sync2[MPS_IDX_EXT_RX] : cur_r.sync2[MPS_IDX_INT_RX];
    newTx = reqExt ? cur_r.sync2[MPS_IDX_EXT_TX] : cur_r.sync2[MPS_IDX_INT_TX];
    case (cur_r.state)
      MPS_RUN: begin
        cur_nxt.rxClk = srcRx;
        cur_nxt.txClk = srcTx;
        // leave run on any source change
        if (!reqValid || (reqExt != cur_r.extSrc)) begin
          cur_nxt.state = MPS_STOPPING;
        end
      end
      MPS_STOPPING: begin
        // only falling edges pass, so no runt high pulse
        cur_nxt.rxClk = cur_r.rxClk & srcRx;
        cur_nxt.txClk = cur_r.txClk & srcTx;
        if (!cur_nxt.rxClk && !cur_nxt.txClk) begin
          cur_nxt.state = MPS_GATED;
        end
      end
      MPS_GATED: begin
        // gated state keeps both clocks low, whatever the select code, until run starts
        cur_nxt.rxClk = 1'b0;
        cur_nxt.txClk = 1'b0;
        if (reqValid) begin
          cur_nxt.extSrc = reqExt;
          // start on a low phase so the first pulse is whole
          if (!newRx && !newTx) begin
            cur_nxt.state = MPS_RUN;
          end
        end
      end
      default: begin
        cur_nxt.state = MPS_GATED;
        cur_nxt.rxClk = 1'b0;
        cur_nxt.txClk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cur_r <= '{sync1: MPS_SYNC_RESET, sync2: MPS_SYNC_RESET, state: MPS_GATED,
                 extSrc: MPS_SRC_RESET, rxClk: 1'b0, txClk: 1'b0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign clkIf.rxClk = cur_r.rxClk;
  assign clkIf.txClk = cur_r.txClk;
  assign clkIf.clocksRunning = (cur_r.state == MPS_RUN);
  assign clkIf.extActive = cur_r.extSrc;

  AST_GATED_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    cur_r.state == MPS_GATED |-> !cur_r.rxClk && !cur_r.txClk)
    else $error("clock high while gated");

  AST_NO_RUNT: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(cur_r.rxClk) || $rose(cur_r.txClk) |-> $past(cur_r.state) == MPS_RUN)
    else $error("clock rose outside run state");

  AST_GATE_CODE: assert property (@(posedge clock) disable iff (!rst_n)
    (cur_r.state == MPS_RUN && clkIf.clkSel[1]) |=> cur_r.state == MPS_STOPPING)
    else $error("gate or reserved code did not stop clocks");

  AST_SRC_FOLLOW: assert property (@(posedge clock) disable iff (!rst_n)
    (cur_r.state == MPS_GATED && clkIf.clkSel == MPS_CLKSEL_EXT) |=> cur_r.extSrc)
    else $error("external source not taken");

  AST_RUN_TRACKS: assert property (@(posedge clock) disable iff (!rst_n)
    (cur_r.state == MPS_RUN && clkIf.clkSel == MPS_CLKSEL_INT && !cur_r.extSrc)
    |=> cur_r.rxClk == $past(cur_r.sync2[MPS_IDX_INT_RX]))
    else $error("running clock does not follow internal source");

  CVR_GATE: cover property (@(posedge clock) disable iff (!rst_n)
    cur_r.state == MPS_STOPPING ##1 cur_r.state == MPS_GATED);
  CVR_EXT_RUN: cover property (@(posedge clock) disable iff (!rst_n)
    cur_r.state == MPS_RUN && cur_r.extSrc && $rose(cur_r.rxClk));
endmodule

// File: sim/mps_phy_model.sv
// mii phy stand-in: free rx/tx clocks, counting receive data, management return
// assumes run comes from the bench; clocks stand still while run is low
`timescale 1ns/100ps
module mps_phy_model #(
  parameter int HALF_NS = 400,
  parameter int PHASE_NS = 130,
  parameter logic [3:0] PAT = 4'h0
) (
  // control
  input wire logic run,
  // mii outputs
  output logic rxClk,
  output logic txClk,
  output logic [3:0] rxd,
  output logic rxDv,
  output logic rxEr,
  output logic crs,
  output logic col,
  output logic mdioIn
);
  logic [3:0] cnt = 4'h0;
  initial begin
    rxClk = 1'b0;
    #(PHASE_NS);
    forever begin
      #(HALF_NS);
      rxClk = run & ~rxClk;
    end
  end
  assign txClk = rxClk;
  always @(posedge rxClk) begin
    cnt <= cnt + 4'h1;
  end
  // pattern keeps the two phys apart on rxd, rxDv and crs; rxEr, col and mdioIn get the same pattern bit
  assign rxd = cnt ^ PAT;
  assign rxDv = cnt[0] ^ PAT[0];
  assign rxEr = cnt[1] ^ PAT[1];
  assign crs = cnt[2] ^ PAT[2];
  assign col = cnt[3] ^ PAT[3];
  assign mdioIn = ~cnt[0] ^ PAT[1];
endmodule

// File: sim/tb.sv
// self-checking bench for the mii port switch
// assumes two phy models with 800 ns clocks at unrelated phases
`timescale 1ns/100ps
module tb;
  import mps_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic externalPortSelect = 1'b0;
  logic managementPortSelect = 1'b0;
  logic [1:0] clockSourceSelect = MPS_CLKSEL_GATED;
  logic macMdc = 1'b0;
  logic macMdioOut = 1'b0;
  logic macMdioOe = 1'b0;
  logic macTxEn = 1'b1;
  logic [3:0] macTxd = 4'ha;
  logic extRun = 1'b1;
  logic clocksRunning, clockSourceExternal, routingMismatch, unsafeSwitch, macRxClk, macTxClk;
  logic macRxDv, macRxEr, macCrs, macCol, intTxEn, extTxEn, macMdioIn;
  logic intMdc, intMdioOut, intMdioOe, extMdc, extMdioOut, extMdioOe;
  logic intRxClk, intTxClk, intRxDv, intRxEr, intCrs, intCol, intMdioIn;
  logic extRxClk, extTxClk, extRxDv, extRxEr, extCrs, extCol, extMdioIn;
  logic [3:0] macRxd, intTxd, extTxd, intRxd, extRxd;
  logic [2:0] hi = 3'h0;
  logic [2:0] he = 3'h0;
  int fail_count = 0;
  int n_tests = 0;

  always #50 clock = ~clock;

  mps_port_switch mps_port_switch_inst (.*);
  mps_phy_model #(.PHASE_NS(130), .PAT(4'h0)) mps_phy_model_inst (.run(rst_n), .rxClk(intRxClk),
    .txClk(intTxClk), .rxd(intRxd), .rxDv(intRxDv), .rxEr(intRxEr), .crs(intCrs), .col(intCol),
    .mdioIn(intMdioIn));
  mps_phy_model #(.PHASE_NS(330), .PAT(4'h5)) mps_phy_model_inst2 (.run(extRun), .rxClk(extRxClk),
    .txClk(extTxClk), .rxd(extRxd), .rxDv(extRxDv), .rxEr(extRxEr), .crs(extCrs), .col(extCol),
    .mdioIn(extMdioIn));

  // raw clocks as the selector sees them, three edges deep
  always @(posedge clock) begin
    hi <= {hi[1:0], intRxClk};
    he <= {he[1:0], extRxClk};
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic waitRun(input logic v);
    int i;
    for (i = 0; i < 60 && clocksRunning !== v; i++) cyc(1);
    chk(clocksRunning, v);
  endtask

  task automatic gateChk(input int n);
    repeat (n) begin
      cyc(1);
      chk({macRxClk, macTxClk, clocksRunning}, 3'h0);
    end
  endtask

  task automatic followChk(input logic p);
    int rises;
    logic last;
    rises = 0;
    last = macRxClk;
    repeat (40) begin
      cyc(1);
      chk({macRxClk, macTxClk}, p ? {he[2], he[2]} : {hi[2], hi[2]});
      rises += int'(macRxClk & ~last);
      last = macRxClk;
    end
    chk(rises > 0, 1'b1);
  endtask

  // halt, gate, wait, route, select, wait: the full switching order
  task automatic switchTo(input logic p, input logic [1:0] g);
    macTxEn = 1'b0; // halt transmitter first
    clockSourceSelect = g;
    waitRun(1'b0);
    // stopping lets a high phase finish before the gate closes
    cyc(8);
    gateChk(40); // five slow periods
    externalPortSelect = p; // clocks already gated
    cyc(1);
    chk({macRxd, macRxDv, macRxEr, macCrs, macCol},
      p ? {extRxd, extRxDv, extRxEr, extCrs, extCol} : {intRxd, intRxDv, intRxEr, intCrs, intCol});
    chk({intTxd, intTxEn, extTxd, extTxEn}, p ? {5'h0, macTxd, macTxEn} : {macTxd, macTxEn, 5'h0});
    clockSourceSelect = p ? MPS_CLKSEL_EXT : MPS_CLKSEL_INT;
    waitRun(1'b1);
    chk(clockSourceExternal, p);
    cyc(4);
    chk({routingMismatch, unsafeSwitch}, 2'h0);
    followChk(p); // five new periods
    macTxEn = 1'b1; // transmitter back on
    cyc(1);
    chk({intTxEn, extTxEn}, p ? 2'h1 : 2'h2);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    stop_test;
  end

  initial begin
    cyc(3);
    chk({macRxClk, macTxClk, clocksRunning, clockSourceExternal}, 4'h0);
    cyc(2);
    rst_n = 1'b1;
    gateChk(20);
    switchTo(1'b0, MPS_CLKSEL_GATED);
    switchTo(1'b1, MPS_CLKSEL_RSVD);
    macTxd = 4'h3;
    switchTo(1'b0, MPS_CLKSEL_GATED);
    extRun = 1'b0; // deselected clock held off
    followChk(1'b0);
    macMdc = 1'b1;
    macMdioOut = 1'b1;
    macMdioOe = 1'b1;
    // management follows its own select while data stays internal
    for (int m = 0; m < 2; m++) begin
      managementPortSelect = m[0]; // no management transfer in flight
      cyc(1);
      chk({intMdc, intMdioOut, intMdioOe, extMdc, extMdioOut, extMdioOe}, m[0] ? 6'h07 : 6'h38);
      chk(macMdioIn, m[0] ? extMdioIn : intMdioIn);
      chk(macRxd, intRxd);
    end
    // routing moved under running clocks must be flagged
    externalPortSelect = 1'b1;
    cyc(1);
    chk({routingMismatch, unsafeSwitch}, 2'h3);
    cyc(1);
    chk({routingMismatch, unsafeSwitch}, 2'h2);
    externalPortSelect = 1'b0;
    cyc(1);
    chk({routingMismatch, unsafeSwitch}, 2'h1);
    stop_test;
  end
endmodule
